//--- include/flight_event_sequencer_consts.svh
// constants for the flight event sequencer
`ifndef FLIGHT_EVENT_SEQUENCER_CONSTS_SVH
`define FLIGHT_EVENT_SEQUENCER_CONSTS_SVH

// ***************************************************************
// timing
// ***************************************************************
`define CLK_HZ           40000000
`define SAMPLE_MS        50
`define TICK_CYCLES      (`CLK_HZ / 1000 * `SAMPLE_MS)
`define TICKS_PER_S      (1000 / `SAMPLE_MS)
`define CONT_PERIOD_S    1
`define CONT_TICKS       (`CONT_PERIOD_S * `TICKS_PER_S)
`define REPEAT_S         10
`define REPEAT_TICKS     (`REPEAT_S * `TICKS_PER_S)
`define FLIGHT_LOG_MS    342000
`define LOG_MIN_SAMPLES  (`FLIGHT_LOG_MS / `SAMPLE_MS)
`define PRELAUNCH_DEPTH  16

// ***************************************************************
// altitude and configuration
// ***************************************************************
`define LAUNCH_FT        160
`define MAIN_BASE_FT     300
`define MAIN_STEP_FT     200
`define MACH_STEP_S      2
`define LAND_FT          300
`define LAND_SINK_FPS    4
`define DRIFT_BAND_FT    20
`define DRIFT_TICKS      20
`define PRESS_MIN        16'h0400
`define PRESS_MAX        16'hFC00

// ***************************************************************
// beeper timing in sample ticks, and beep count for a zero digit
// ***************************************************************
`define BEEP_LONG_TICKS  4'hA
`define BEEP_SHORT_TICKS 4'h3
`define BEEP_GAP_TICKS   4'hA
`define ZERO_BEEPS       4'hA

`endif

//--- include/flight_event_sequencer_pkg.sv
// types for the flight event sequencer
package flight_event_sequencer_pkg;

   typedef enum logic [3:0] {
      PH_CAPTURE, PH_CHECK, PH_ANN_MACH, PH_ANN_MAIN, PH_ANN_PEAK,
      PH_PAD, PH_MACH_WAIT, PH_ASCENT, PH_DESCENT, PH_LANDED, PH_ERROR
   } phase_t;

   typedef enum logic [2:0] {
      BP_IDLE, BP_SEP, BP_GAP, BP_DIGIT, BP_ON, BP_OFF
   } beep_t;

   typedef struct packed {
      logic power_ok;
      logic drogue_cont;
      logic main_cont;
   } igniter_status_t;

   typedef struct packed {
      logic               we;
      logic [15:0]        addr;
      logic signed [17:0] data;
   } log_wr_t;

   typedef struct packed {
      logic        we;
      logic [16:0] data;
   } nvm_wr_t;

   typedef struct packed {
      phase_t                  phase;
      beep_t                   bst;
      logic [2:0]              main_code;
      logic [2:0]              mach_code;
      logic [15:0]             ground;
      logic signed [17:0]      alt;
      logic signed [17:0]      prev_alt;
      logic [16:0]             peak;
      logic [31:0]             tick_cnt;
      logic                    tick;
      logic [8:0]              wait_cnt;
      logic [4:0]              cont_cnt;
      logic [4:0]              drift_cnt;
      logic [15:0][17:0]       ring;
      logic [3:0]              ring_ptr;
      logic [4:0]              copy_cnt;
      log_wr_t                 log_wr;
      nvm_wr_t                 nvm_wr;
      logic                    drogue;
      logic                    main_fire;
      logic                    beeper;
      logic                    error;
      igniter_status_t         cont_status;
      logic [16:0]             ann_rem;
      logic [2:0]              digit_idx;
      logic [3:0]              digit;
      logic [3:0]              beeps;
      logic [3:0]              btimer;
      logic                    started;
   } state_t;

endpackage

//--- hw/flight_event_sequencer.sv
// flight event sequencer: sampling, launch, apogee, main, logging, beeper
`timescale 1ns/1ps
`include "flight_event_sequencer_consts.svh"

module flight_event_sequencer #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int LOG_DEPTH   = 8192
) (
   // clock and reset
   input  wire logic                                  sys_clk_i,
   input  wire logic                                  reset_n_i,
   // configuration switches
   input  wire logic                                  main_level_select_msb,
   input  wire logic                                  main_level_select_mid,
   input  wire logic                                  main_level_select_lsb,
   input  wire logic                                  mach_wait_select_msb,
   input  wire logic                                  mach_wait_select_mid,
   input  wire logic                                  mach_wait_select_lsb,
   // sensor and igniter sense
   input  wire logic [15:0]                           pressure_i,
   input  wire flight_event_sequencer_pkg::igniter_status_t igniter_i,
   input  wire logic [16:0]                           nvm_peak_i,
   // igniters, beeper, status
   output logic                                       drogue_fire_o,
   output logic                                       main_fire_o,
   output logic                                       beeper_o,
   output logic                                       error_o,
   output flight_event_sequencer_pkg::igniter_status_t cont_status_o,
   // log and nonvolatile writes
   output flight_event_sequencer_pkg::log_wr_t        log_wr_o,
   output flight_event_sequencer_pkg::nvm_wr_t        nvm_wr_o
);
   import flight_event_sequencer_pkg::*;

   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (TICK_CYCLES < 32) begin : g_tick_chk
      $error("TICK_CYCLES too small for the launch log copy");
   end
   if (LOG_DEPTH < `LOG_MIN_SAMPLES + `PRELAUNCH_DEPTH || LOG_DEPTH > 65536) begin : g_log_chk
      $error("LOG_DEPTH cannot hold the flight");
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [16:0] pow10(input logic [2:0] idx);
      case (idx)
         3'h4:    pow10 = 17'h02710;
         3'h3:    pow10 = 17'h003E8;
         3'h2:    pow10 = 17'h00064;
         3'h1:    pow10 = 17'h0000A;
         default: pow10 = 17'h00001;
      endcase
   endfunction

   state_t s_reg;
   state_t s_next;

   logic signed [17:0] alt_now;
   logic signed [17:0] rate;
   logic [16:0]        main_level;
   logic [8:0]         mach_ticks;
   logic               press_ok;

   assign alt_now    = $signed({2'h0, s_reg.ground}) - $signed({2'h0, pressure_i});
   assign rate       = alt_now - s_reg.alt;
   assign main_level = 17'(`MAIN_BASE_FT + `MAIN_STEP_FT * s_reg.main_code);
   assign mach_ticks = 9'(`MACH_STEP_S * `TICKS_PER_S * s_reg.mach_code);
   assign press_ok   = pressure_i >= `PRESS_MIN && pressure_i <= `PRESS_MAX;

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic        ann_go;
      logic [16:0] ann_val;
      logic [16:0] peak_now;
      ann_go   = 1'b0;
      ann_val  = 17'h00000;
      peak_now = s_reg.peak;
      s_next   = s_reg;
      s_next.log_wr.we = 1'b0;
      s_next.nvm_wr.we = 1'b0;

      // sample period tick
      s_next.tick = (s_reg.tick_cnt == 32'(TICK_CYCLES - 1));
      s_next.tick_cnt = s_next.tick ? 32'h0 : s_reg.tick_cnt + 32'h1;

      // launch log copy, oldest first
      if (s_reg.copy_cnt != 5'h00) begin
         s_next.log_wr.we   = 1'b1;
         s_next.log_wr.data = s_reg.ring[4'(s_reg.ring_ptr + 4'(5'h10 - s_reg.copy_cnt))];
         s_next.log_wr.addr = s_reg.log_wr.addr + 16'h1;
         s_next.copy_cnt    = s_reg.copy_cnt - 5'h01;
      end

      // flight log append and altitude tracking
      if (s_reg.tick && (s_reg.phase == PH_MACH_WAIT || s_reg.phase == PH_ASCENT ||
                         s_reg.phase == PH_DESCENT)) begin
         s_next.prev_alt = s_reg.alt;
         s_next.alt      = alt_now;
         if (alt_now > 0 && 17'(alt_now) > s_reg.peak) begin
            peak_now = 17'(alt_now);
         end
         s_next.peak = peak_now;
         if (32'(s_reg.log_wr.addr) < 32'(LOG_DEPTH - 1)) begin
            s_next.log_wr.we   = 1'b1;
            s_next.log_wr.data = alt_now;
            s_next.log_wr.addr = s_reg.log_wr.addr + 16'h1;
         end
      end

      unique case (s_reg.phase)
         PH_CAPTURE: begin
            s_next.main_code = {main_level_select_msb, main_level_select_mid,
                                main_level_select_lsb};
            s_next.mach_code = {mach_wait_select_msb, mach_wait_select_mid,
                                mach_wait_select_lsb};
            s_next.phase = PH_CHECK;
         end
         PH_CHECK: begin
            if (s_reg.tick) begin
               if (!press_ok) begin
                  s_next.error = 1'b1;
                  s_next.phase = PH_ERROR;
               end else begin
                  s_next.ground = pressure_i;
                  ann_go  = 1'b1;
                  ann_val = 17'(`MACH_STEP_S * s_reg.mach_code);
                  s_next.phase = PH_ANN_MACH;
               end
            end
         end
         PH_ANN_MACH: begin
            if (s_reg.bst == BP_IDLE) begin
               ann_go  = 1'b1;
               ann_val = main_level;
               s_next.phase = PH_ANN_MAIN;
            end
         end
         PH_ANN_MAIN: begin
            if (s_reg.bst == BP_IDLE) begin
               ann_go  = 1'b1;
               ann_val = nvm_peak_i;
               s_next.phase = PH_ANN_PEAK;
            end
         end
         PH_ANN_PEAK: begin
            if (s_reg.bst == BP_IDLE) begin
               s_next.phase = PH_PAD;
            end
         end
         PH_PAD: begin
            if (s_reg.tick) begin
               s_next.alt      = alt_now;
               s_next.prev_alt = s_reg.alt;
               s_next.ring[s_reg.ring_ptr] = alt_now;
               s_next.ring_ptr = s_reg.ring_ptr + 4'h1;
               // continuity report
               if (s_reg.cont_cnt == 5'(`CONT_TICKS - 1)) begin
                  s_next.cont_cnt    = 5'h00;
                  s_next.cont_status = igniter_i;
               end else begin
                  s_next.cont_cnt = s_reg.cont_cnt + 5'h01;
               end
               // slow drift follow
               if (alt_now != 0 && alt_now < 18'sd20 && alt_now > -18'sd20) begin
                  if (s_reg.drift_cnt == 5'(`DRIFT_TICKS - 1)) begin
                     s_next.drift_cnt = 5'h00;
                     s_next.ground = (alt_now > 0) ? s_reg.ground - 16'h1
                                                   : s_reg.ground + 16'h1;
                  end else begin
                     s_next.drift_cnt = s_reg.drift_cnt + 5'h01;
                  end
               end else begin
                  s_next.drift_cnt = 5'h00;
               end
               if (alt_now > 18'(`LAUNCH_FT)) begin
                  s_next.copy_cnt    = 5'h10;
                  s_next.log_wr.addr = 16'hFFFF;
                  s_next.peak        = 17'(alt_now);
                  s_next.wait_cnt    = mach_ticks;
                  s_next.phase = (s_reg.mach_code == 3'h0) ? PH_ASCENT : PH_MACH_WAIT;
               end
            end
         end
         PH_MACH_WAIT: begin
            if (s_reg.tick) begin
               s_next.wait_cnt = s_reg.wait_cnt - 9'h001;
               if (s_reg.wait_cnt == 9'h001) begin
                  s_next.phase = PH_ASCENT;
               end
            end
         end
         PH_ASCENT: begin
            if (s_reg.tick && rate <= 0) begin
               s_next.drogue      = 1'b1;
               s_next.nvm_wr.we   = 1'b1;
               s_next.nvm_wr.data = peak_now;
               s_next.phase = PH_DESCENT;
            end
         end
         PH_DESCENT: begin
            if (s_reg.tick) begin
               if (alt_now <= $signed({1'b0, main_level})) begin
                  s_next.main_fire = 1'b1;
               end
               if (alt_now < 18'(`LAND_FT) &&
                   (-rate) * 18'(`TICKS_PER_S) < 18'(`LAND_SINK_FPS)) begin
                  s_next.phase    = PH_LANDED;
                  s_next.wait_cnt = 9'h000;
                  ann_go  = 1'b1;
                  ann_val = s_reg.peak;
               end
            end
         end
         PH_LANDED: begin
            if (s_reg.bst == BP_IDLE && s_reg.tick) begin
               if (s_reg.wait_cnt == 9'(`REPEAT_TICKS - 1)) begin
                  s_next.wait_cnt = 9'h000;
                  ann_go  = 1'b1;
                  ann_val = s_reg.peak;
               end else begin
                  s_next.wait_cnt = s_reg.wait_cnt + 9'h001;
               end
            end
         end
         PH_ERROR: begin
            s_next.error = 1'b1;
         end
      endcase

      // ***************************************************************
      // beeper number sender
      // ***************************************************************
      unique case (s_reg.bst)
         BP_IDLE: begin
            if (ann_go) begin
               s_next.bst       = BP_SEP;
               s_next.beeper    = 1'b1;
               s_next.btimer    = `BEEP_LONG_TICKS;
               s_next.ann_rem   = ann_val;
               s_next.digit_idx = 3'h4;
               s_next.started   = 1'b0;
            end
         end
         BP_SEP, BP_GAP, BP_ON, BP_OFF: begin
            if (s_reg.tick) begin
               s_next.btimer = s_reg.btimer - 4'h1;
               if (s_reg.btimer == 4'h1) begin
                  s_next.btimer = `BEEP_SHORT_TICKS;
                  s_next.beeper = 1'b0;
                  if (s_reg.bst == BP_SEP) begin
                     s_next.btimer = `BEEP_GAP_TICKS;
                     s_next.bst = BP_GAP;
                  end else if (s_reg.bst == BP_GAP) begin
                     s_next.digit = 4'h0;
                     s_next.bst = BP_DIGIT;
                  end else if (s_reg.bst == BP_ON) begin
                     s_next.beeps = s_reg.beeps - 4'h1;
                     s_next.bst = BP_OFF;
                  end else if (s_reg.beeps != 4'h0) begin
                     s_next.beeper = 1'b1;
                     s_next.bst = BP_ON;
                  end else if (s_reg.digit_idx == 3'h0) begin
                     s_next.bst = BP_IDLE;
                  end else begin
                     s_next.digit_idx = s_reg.digit_idx - 3'h1;
                     s_next.btimer = `BEEP_GAP_TICKS;
                     s_next.bst = BP_GAP;
                  end
               end
            end
         end
         BP_DIGIT: begin
            if (s_reg.ann_rem >= pow10(s_reg.digit_idx)) begin
               s_next.ann_rem = s_reg.ann_rem - pow10(s_reg.digit_idx);
               s_next.digit   = s_reg.digit + 4'h1;
            end else if (s_reg.digit == 4'h0 && !s_reg.started &&
                         s_reg.digit_idx != 3'h0) begin
               s_next.digit_idx = s_reg.digit_idx - 3'h1;
            end else begin
               s_next.beeps   = (s_reg.digit == 4'h0) ? `ZERO_BEEPS : s_reg.digit;
               s_next.started = 1'b1;
               s_next.beeper  = 1'b1;
               s_next.btimer  = `BEEP_SHORT_TICKS;
               s_next.bst     = BP_ON;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg       <= '0;
         s_reg.phase <= PH_CAPTURE;
         s_reg.bst   <= BP_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign drogue_fire_o = s_reg.drogue;
   assign main_fire_o   = s_reg.main_fire;
   assign beeper_o      = s_reg.beeper;
   assign error_o       = s_reg.error;
   assign cont_status_o = s_reg.cont_status;
   assign log_wr_o      = s_reg.log_wr;
   assign nvm_wr_o      = s_reg.nvm_wr;

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_launch;
      s_reg.phase == PH_PAD && s_reg.tick && alt_now > 18'sd160;
   endsequence
   sequence s_copy16;
      log_wr_o.we [*8] ##1 log_wr_o.we [*8];
   endsequence

   property p_switch_hold;
      s_reg.phase != PH_CAPTURE |=> $stable(s_reg.main_code) && $stable(s_reg.mach_code);
   endproperty
   a_switch_hold: assert property (p_switch_hold) else $error("switches changed");

   property p_press_err;
      s_reg.phase == PH_CHECK && s_reg.tick && !press_ok |=> error_o ##1 error_o;
   endproperty
   a_press_err: assert property (p_press_err) else $error("no error on bad pressure");

   property p_launch;
      s_launch |=> s_reg.phase inside {PH_MACH_WAIT, PH_ASCENT};
   endproperty
   a_launch: assert property (p_launch) else $error("launch missed");

   property p_copy;
      s_launch |=> ##1 s_copy16;
   endproperty
   a_copy: assert property (p_copy) else $error("prelaunch copy short");

   property p_mach_safe;
      s_reg.phase == PH_MACH_WAIT |-> !drogue_fire_o;
   endproperty
   a_mach_safe: assert property (p_mach_safe) else $error("drogue during mach wait");

   property p_apogee;
      s_reg.phase == PH_ASCENT && s_reg.tick && rate <= 0
         |=> drogue_fire_o && nvm_wr_o.we ##1 !nvm_wr_o.we && drogue_fire_o;
   endproperty
   a_apogee: assert property (p_apogee) else $error("apogee action wrong");

   property p_peak_store;
      $rose(nvm_wr_o.we) |-> nvm_wr_o.data == s_reg.peak && $rose(drogue_fire_o);
   endproperty
   a_peak_store: assert property (p_peak_store) else $error("peak store wrong");

   property p_main;
      s_reg.phase == PH_DESCENT && s_reg.tick && alt_now <= $signed({1'b0, main_level})
         |=> main_fire_o;
   endproperty
   a_main: assert property (p_main) else $error("main not fired");

   property p_landed;
      s_reg.phase == PH_LANDED |=> !log_wr_o.we;
   endproperty
   a_landed: assert property (p_landed) else $error("logging after stop");

   property p_main_fire_hold;
      main_fire_o |=> main_fire_o;
   endproperty
   a_main_fire_hold: assert property (p_main_fire_hold) else $error("main dropped");

endmodule

//--- dv/flight_sensor_model.sv
// pressure sensor and nonvolatile peak memory model
`timescale 1ns/1ps
module flight_sensor_model
   import flight_event_sequencer_pkg::*;
#(
   parameter logic [15:0] GROUND_P  = 16'h8000,
   parameter logic [16:0] PEAK_INIT = 17'h004D2
) (
   // clock
   input  wire logic                                sys_clk_i,
   // bench stimulus
   input  wire logic [15:0]                         alt_ft_i,
   input  wire logic                                bad_i,
   // device side
   input  wire flight_event_sequencer_pkg::nvm_wr_t nvm_wr_i,
   output logic [15:0]                              pressure_o,
   output logic [16:0]                              nvm_peak_o
);
   // one count per foot, higher count is lower
   assign pressure_o = bad_i ? 16'h0100 : GROUND_P - alt_ft_i;
   // stored peak survives resets
   initial nvm_peak_o = PEAK_INIT;
   always @(posedge sys_clk_i) begin
      if (nvm_wr_i.we === 1'b1) begin
         nvm_peak_o <= nvm_wr_i.data;
      end
   end
endmodule

//--- dv/flight_event_sequencer_tb.sv
// self-checking bench for the flight event sequencer
`timescale 1ns/1ps
module flight_event_sequencer_tb;
   import flight_event_sequencer_pkg::*;
   localparam int TICK = 40;
   logic            sys_clk_i, reset_n_i, bad, wig, d_prev, m_prev;
   logic [2:0]      main_sw, mach_sw, main_code, mach_code;
   logic [15:0]     alt_ft, pressure;
   logic [16:0]     nvm_peak;
   igniter_status_t ign, cont;
   logic            drogue, main_f, beeper, error;
   log_wr_t         log_wr;
   nvm_wr_t         nvm_wr;
   logic [31:0]     lfsr;
   logic [17:0]     exp_q[$];
   logic [17:0]     peak, lvl;
   int              n_mismatch, n_tests, n_log, t_launch, cyc, i, k, n_up;

   flight_event_sequencer #(.TICK_CYCLES(TICK)) DUT (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .main_level_select_msb(main_sw[2]), .main_level_select_mid(main_sw[1]),
      .main_level_select_lsb(main_sw[0]), .mach_wait_select_msb(mach_sw[2]),
      .mach_wait_select_mid(mach_sw[1]), .mach_wait_select_lsb(mach_sw[0]),
      .pressure_i(pressure), .igniter_i(ign), .nvm_peak_i(nvm_peak),
      .drogue_fire_o(drogue), .main_fire_o(main_f), .beeper_o(beeper), .error_o(error),
      .cont_status_o(cont), .log_wr_o(log_wr), .nvm_wr_o(nvm_wr));

   flight_sensor_model u_sensor (.sys_clk_i(sys_clk_i), .alt_ft_i(alt_ft), .bad_i(bad),
      .nvm_wr_i(nvm_wr), .pressure_o(pressure), .nvm_peak_o(nvm_peak));

   function automatic logic [31:0] next_rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string nm, input logic [17:0] e, input logic [17:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_of_test();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n * TICK) @(posedge sys_clk_i);
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   // switches wiggle after capture
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      lfsr <= next_rnd(lfsr);
      if (wig) begin
         {main_sw, mach_sw} <= lfsr[5:0];
      end
   end

   // output watcher
   always @(negedge sys_clk_i) begin
      if (reset_n_i === 1'b1 && log_wr.we === 1'b1) begin
         if (n_log == 0) t_launch = cyc;
         check("log_addr", 18'(n_log), 18'(log_wr.addr));
         n_log++;
      end
      if (reset_n_i === 1'b1 && nvm_wr.we === 1'b1) begin
         check("nvm_peak", exp_q.pop_front(), {1'b0, nvm_wr.data});
      end
      if (drogue === 1'b1 && d_prev !== 1'b1) begin
         check("apogee_alt", exp_q.pop_front(), log_wr.data);
         check("mach_wait", 18'h1, 18'(cyc - t_launch > mach_code * 40 * TICK));
      end
      if (main_f === 1'b1 && m_prev !== 1'b1) begin
         check("main_alt", exp_q.pop_front(), log_wr.data);
      end
      d_prev = drogue;
      m_prev = main_f;
   end

   initial begin
      n_mismatch = 0; n_tests = 0; n_log = 0; t_launch = 0; cyc = 0;
      reset_n_i = 1'b0; bad = 1'b0; wig = 1'b0; alt_ft = 16'h0000;
      lfsr = next_rnd(32'h052bb3d7);
      main_code = lfsr[2:0];
      mach_code = lfsr[5:3];
      ign = lfsr[8:6] | 3'h4;
      main_sw = main_code;
      mach_sw = mach_code;
      repeat (10) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      wig <= 1'b1;
      // pad reached once continuity is reported
      for (i = 0; i < 1000 * TICK && cont !== ign; i++) @(posedge sys_clk_i);
      check("cont_status", 18'(ign), 18'(cont));
      check("error_ok", 18'h0, 18'(error));
      if (cont !== ign) end_of_test();
      lvl = 18'(300 + 200 * main_code);
      n_up = mach_code * 40 + 20 + lvl / 50;
      peak = 18'(50 * n_up);
      exp_q.push_back(peak);
      exp_q.push_back(peak - 18'h32);
      exp_q.push_back(lvl);
      for (i = 1; i <= n_up; i++) begin
         alt_ft <= 16'(50 * i);
         step(1);
      end
      for (i = n_up - 1; i >= 0; i--) begin
         alt_ft <= 16'(50 * i);
         step(1);
      end
      step(20);
      k = n_log;
      step(40);
      check("log_stop", 18'(k), 18'(n_log));
      check("log_len", 18'(16 + 2 * n_up - 3), 18'(k));
      check("drogue", 18'h1, 18'(drogue));
      check("main", 18'h1, 18'(main_f));
      check("events", 18'h0, 18'(exp_q.size()));
      for (i = 0; i < 400 * TICK && beeper !== 1'b1; i++) @(posedge sys_clk_i);
      check("peak_beep", 18'h1, 18'(beeper));
      // out of range pressure at power-up
      bad <= 1'b1;
      reset_n_i <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      step(3);
      check("error_bad", 18'h1, 18'(error));
      check("nvm_kept", peak, {1'b0, nvm_peak});
      end_of_test();
   end
endmodule
